// file: design/t8cc_top.sv
// Notes on behaviour
// - Timer clock is system clock, or crystal when async select is set.
// - Clock select zero stops the counter; one ticks it once per clock, two to seven divide by 8 to 1024.
// - Counter value reads and writes work with or without timer clock.
// - A CPU counter write beats clear, increment and decrement.
// - Counter steps per timer clock; top and bottom indications shown.
// - Counter equal to active compare sets compare flag next timer clock.
// - Enabled flag requests interrupt; service or writing one clears it.
// - Compare value buffered in PWM modes, direct in the other modes.
// - Buffered compare copied to active only at top.
// - Compare accesses reach the buffer when buffered, else active.
// - Force strobe acts like a match outside PWM modes, without flag or counter change.
// - A counter write blocks the match on the next timer clock.
// - Output state keeps its value across mode changes.
// - Output mode unbuffered; acts from the first match after write.
// - Nonzero output mode puts the output state on the pin.
// - Output mode zero leaves the output state alone on match.
// - Waveform mode alone sets the counting sequence.
// - Mode zero counts up only and wraps from FF to 00.
// - Normal overflow flag sets as the count becomes zero.
// - Mode two clears the counter on compare match.
// - Mode three counts single slope from zero to max.
// - Mode one counts up to max then down to zero.
// - Counter maximum is FF and minimum is 00.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
module t8cc_top import t8cc_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic crystal_in_pin,
    input wire logic port_value_bit,
    input wire logic pin_direction_bit,
    input wire logic cmp_irq_ack,
    input wire logic ovf_irq_ack,
    output logic compare_irq,
    output logic overflow_irq,
    output logic pin_out,
    output logic pin_oe
);
    typedef struct packed {
        logic [2:0] cs;
        t8cc_wm_e wm;
        logic [1:0] com;
        logic async_sel;
        logic [7:0] cnt;
        logic down;
        logic [7:0] ocr_act;
        logic [7:0] ocr_buf;
        logic block;
        logic cmp_flag;
        logic ovf_flag;
        logic cmp_ie;
        logic ovf_ie;
        logic [7:0] rdata;
    } t8cc_top_s;
    t8cc_top_s st;
    t8cc_top_s next_st;

    t8cc_if tif ();

    logic wr_ctrl;
    logic wr_count;
    logic wr_compare;
    logic wr_flags;
    logic wr_inten;
    logic wr_async;
    logic pwm;
    logic tick;
    logic match_raw;
    logic match_ev;
    logic at_top;
    logic at_bottom;
    logic ovf_set;
    logic [7:0] rd_val;

    // Register write decode
    assign wr_ctrl = reg_write && (reg_addr == OFS_CTRL);
    assign wr_count = reg_write && (reg_addr == OFS_COUNT);
    assign wr_compare = reg_write && (reg_addr == OFS_COMPARE);
    assign wr_flags = reg_write && (reg_addr == OFS_FLAGS);
    assign wr_inten = reg_write && (reg_addr == OFS_INTEN);
    assign wr_async = reg_write && (reg_addr == OFS_ASYNC);

    // Comparator and count limits
    assign pwm = (st.wm == T8CC_WM_PHASE) || (st.wm == T8CC_WM_FAST);
    assign tick = tif.tick;
    assign match_raw = (st.cnt == st.ocr_act);
    assign match_ev = tick && match_raw && !st.block;
    assign at_top = (st.cnt == COUNT_MAX);
    assign at_bottom = (st.cnt == COUNT_BOTTOM);

    // Overflow events per counting sequence
    always_comb begin
        ovf_set = 1'b0;
        if (tick && !wr_count) begin
            unique case (st.wm)
                T8CC_WM_NORMAL, T8CC_WM_CLEAR: ovf_set = at_top;
                T8CC_WM_FAST: ovf_set = (st.cnt == (COUNT_MAX - COUNT_ONE));
                T8CC_WM_PHASE: ovf_set = st.down && (st.cnt == COUNT_ONE);
            endcase
        end
    end

    // Signals handed to clock select and waveform units
    assign tif.clock_select = st.cs;
    assign tif.async_clock_select = st.async_sel;
    assign tif.waveform_mode = st.wm;
    assign tif.compare_output_mode = st.com;
    assign tif.match_ev = match_ev;
    assign tif.force_ev = wr_ctrl && reg_wdata[CTRL_FORCE_BIT] &&
        !pwm;
    assign tif.bottom_ev = tick && at_top && (st.wm == T8CC_WM_FAST);
    assign tif.count_down = st.down;

    t8cc_clk_sel u_clk_sel (
        .clk(clk),
        .rst_n(rst_n),
        .crystal_in_pin(crystal_in_pin),
        .bus(tif.clk)
    );

    t8cc_wave u_wave (
        .clk(clk),
        .rst_n(rst_n),
        .bus(tif.wave)
    );

    // Read value mux, unmapped offsets read zero
    always_comb begin
        rd_val = 8'h00;
        unique case (reg_addr)
            OFS_CTRL: begin
                rd_val[CTRL_CS_LSB +: 3] = st.cs;
                rd_val[CTRL_WM_LSB +: 2] = st.wm;
                rd_val[CTRL_COM_LSB +: 2] = st.com;
            end
            OFS_COUNT: rd_val = st.cnt;
            OFS_COMPARE: rd_val = pwm ? st.ocr_buf : st.ocr_act;
            OFS_FLAGS: begin
                rd_val[FLAG_CMP_BIT] = st.cmp_flag;
                rd_val[FLAG_OVF_BIT] = st.ovf_flag;
                rd_val[FLAG_TOP_BIT] = at_top;
                rd_val[FLAG_BOT_BIT] = at_bottom;
            end
            OFS_INTEN: begin
                rd_val[INT_CMP_BIT] = st.cmp_ie;
                rd_val[INT_OVF_BIT] = st.ovf_ie;
            end
            OFS_ASYNC: rd_val[ASYNC_SEL_BIT] = st.async_sel;
            default: rd_val = 8'h00;
        endcase
    end

    // Next state: counter, compare registers, flags and controls
    always_comb begin
        next_st = st;
        next_st.rdata = reg_read ? rd_val : 8'h00;
        // Counting sequence chosen by waveform mode only
        if (tick) begin
            unique case (st.wm)
                T8CC_WM_NORMAL: begin
                    next_st.cnt = st.cnt + COUNT_ONE;
                end
                T8CC_WM_FAST: begin
                    next_st.cnt = st.cnt + COUNT_ONE;
                end
                T8CC_WM_CLEAR: begin
                    next_st.cnt = match_ev ? COUNT_BOTTOM
                                           : st.cnt + COUNT_ONE;
                end
                T8CC_WM_PHASE: begin
                    if (!st.down && at_top) begin
                        next_st.down = 1'b1;
                        next_st.cnt = st.cnt - COUNT_ONE;
                    end else if (st.down && at_bottom) begin
                        next_st.down = 1'b0;
                        next_st.cnt = st.cnt + COUNT_ONE;
                    end else if (st.down) begin
                        next_st.cnt = st.cnt - COUNT_ONE;
                    end else begin
                        next_st.cnt = st.cnt + COUNT_ONE;
                    end
                end
            endcase
            next_st.block = 1'b0;
        end
        if (st.wm != T8CC_WM_PHASE) begin
            next_st.down = 1'b0;
        end
        // CPU write wins over any count and arms match blocking
        if (wr_count) begin
            next_st.cnt = reg_wdata;
            next_st.block = 1'b1;
        end
        // Buffered copy at top of the sequence in PWM modes
        if (pwm && tick && at_top) begin
            next_st.ocr_act = st.ocr_buf;
        end
        if (wr_compare) begin
            next_st.ocr_buf = reg_wdata;
            if (!pwm) begin
                next_st.ocr_act = reg_wdata;
            end
        end
        // Sticky flags: the set beats a clear in the same cycle
        if ((wr_flags && reg_wdata[FLAG_CMP_BIT]) || cmp_irq_ack) begin
            next_st.cmp_flag = 1'b0;
        end
        if (match_ev) begin
            next_st.cmp_flag = 1'b1;
        end
        if ((wr_flags && reg_wdata[FLAG_OVF_BIT]) || ovf_irq_ack) begin
            next_st.ovf_flag = 1'b0;
        end
        if (ovf_set) begin
            next_st.ovf_flag = 1'b1;
        end
        // Control writes take effect at once
        if (wr_ctrl) begin
            next_st.cs = reg_wdata[CTRL_CS_LSB +: 3];
            next_st.wm = t8cc_wm_e'(reg_wdata[CTRL_WM_LSB +: 2]);
            next_st.com = reg_wdata[CTRL_COM_LSB +: 2];
        end
        if (wr_inten) begin
            next_st.cmp_ie = reg_wdata[INT_CMP_BIT];
            next_st.ovf_ie = reg_wdata[INT_OVF_BIT];
        end
        if (wr_async) begin
            next_st.async_sel = reg_wdata[ASYNC_SEL_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs: read data, interrupt requests and pin override
    assign reg_rdata = st.rdata;
    assign compare_irq = st.cmp_flag && st.cmp_ie;
    assign overflow_irq = st.ovf_flag && st.ovf_ie;
    assign pin_out = (st.com != 2'h0) ? tif.compare_output_state
                                      : port_value_bit;
    assign pin_oe = pin_direction_bit;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_write_wins: assert property (
        wr_count |=> st.cnt == $past(reg_wdata))
        else $error("counter write lost");
    a_stopped_hold: assert property (
        st.cs == 3'h0 && !wr_count |=> $stable(st.cnt))
        else $error("counter moved while stopped");
    a_match_flag: assert property (
        tick && match_raw && !st.block |=> st.cmp_flag)
        else $error("match did not set compare flag");
    a_block_arm: assert property (
        wr_count |=> st.block)
        else $error("counter write did not arm match blocking");
    a_block_keep: assert property (
        st.block && !tick |=> st.block)
        else $error("match blocking lost while timer clock idle");
    a_block_match: assert property (
        st.block && tick && match_raw |=> !$rose(st.cmp_flag))
        else $error("match not blocked after counter write");
    a_flag_ack: assert property (
        cmp_irq_ack && !match_ev |=> !st.cmp_flag)
        else $error("compare flag survived service");
    a_normal_wrap: assert property (
        tick && st.wm == T8CC_WM_NORMAL && at_top && !wr_count
        |=> st.cnt == 8'h00 && st.ovf_flag)
        else $error("normal wrap or overflow wrong");
    a_match_clear: assert property (
        match_ev && st.wm == T8CC_WM_CLEAR && !wr_count
        |=> st.cnt == 8'h00)
        else $error("counter not cleared on match");
    a_phase_turn: assert property (
        tick && st.wm == T8CC_WM_PHASE && !st.down && at_top &&
        !wr_count |=> st.down && st.cnt == 8'hFE)
        else $error("phase mode did not turn at max");
    a_buf_hold: assert property (
        pwm && !(tick && at_top) && !wr_ctrl |=> $stable(st.ocr_act))
        else $error("active compare changed away from top");
    a_direct_write: assert property (
        !pwm && wr_compare |=> st.ocr_act == $past(reg_wdata))
        else $error("direct compare write lost");
    a_force_quiet: assert property (
        tif.force_ev && !tick && !wr_count |=> $stable(st.cnt) &&
        st.cmp_flag == ($past(st.cmp_flag) && !$past(cmp_irq_ack)))
        else $error("force touched counter or flag");
    a_pin_override: assert property (
        st.com != 2'h0 |-> pin_out == tif.compare_output_state)
        else $error("pin not overridden by output state");
endmodule

// file: include/t8cc_pkg.sv
package t8cc_pkg;
    // Register offsets on the plain register port
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_COUNT = 3'h1;
    localparam logic [2:0] OFS_COMPARE = 3'h2;
    localparam logic [2:0] OFS_FLAGS = 3'h3;
    localparam logic [2:0] OFS_INTEN = 3'h4;
    localparam logic [2:0] OFS_ASYNC = 3'h5;
    // Field positions
    localparam int CTRL_CS_LSB = 0;
    localparam int CTRL_WM_LSB = 3;
    localparam int CTRL_COM_LSB = 5;
    localparam int CTRL_FORCE_BIT = 7;
    localparam int FLAG_CMP_BIT = 0;
    localparam int FLAG_OVF_BIT = 1;
    localparam int FLAG_TOP_BIT = 2;
    localparam int FLAG_BOT_BIT = 3;
    localparam int INT_CMP_BIT = 0;
    localparam int INT_OVF_BIT = 1;
    localparam int ASYNC_SEL_BIT = 0;
    // Values after reset and counter limits
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    // Prescaler width and tick masks (divide by mask plus one)
    localparam int PRE_W = 10;
    localparam logic [9:0] PRE_MASK_8 = 10'h007;
    localparam logic [9:0] PRE_MASK_32 = 10'h01F;
    localparam logic [9:0] PRE_MASK_64 = 10'h03F;
    localparam logic [9:0] PRE_MASK_128 = 10'h07F;
    localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
    typedef enum logic [1:0] {
        T8CC_WM_NORMAL = 2'b00,
        T8CC_WM_PHASE = 2'b01,
        T8CC_WM_CLEAR = 2'b10,
        T8CC_WM_FAST = 2'b11
    } t8cc_wm_e;
endpackage

// file: include/t8cc_if.sv
`timescale 1ns/1ps
interface t8cc_if;
    import t8cc_pkg::*;
    logic [2:0] clock_select;
    logic async_clock_select;
    logic tick;
    t8cc_wm_e waveform_mode;
    logic [1:0] compare_output_mode;
    logic match_ev;
    logic force_ev;
    logic bottom_ev;
    logic count_down;
    logic compare_output_state;
    modport core (output clock_select, output async_clock_select,
        output waveform_mode, output compare_output_mode,
        output match_ev, output force_ev, output bottom_ev,
        output count_down, input tick, input compare_output_state);
    modport clk (input clock_select, input async_clock_select,
        output tick);
    modport wave (input waveform_mode, input compare_output_mode,
        input match_ev, input force_ev, input bottom_ev,
        input count_down, output compare_output_state);
endinterface

// file: design/t8cc_clk_sel.sv
`timescale 1ns/1ps
module t8cc_clk_sel import t8cc_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic crystal_in_pin,
    t8cc_if.clk bus
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic xtal_prev;
        logic [PRE_W-1:0] pre;
    } t8cc_cs_s;
    t8cc_cs_s st;
    t8cc_cs_s next_st;
    logic src_en;
    logic [PRE_W-1:0] mask;

    // Source enable, tick mask and prescaler advance
    always_comb begin
        next_st = st;
        unique case (bus.clock_select)
            3'h2: mask = PRE_MASK_8;
            3'h3: mask = PRE_MASK_32;
            3'h4: mask = PRE_MASK_64;
            3'h5: mask = PRE_MASK_128;
            3'h6: mask = PRE_MASK_256;
            3'h7: mask = PRE_MASK_1024;
            default: mask = '0;
        endcase
        // Crystal edge only after two flops; system clock otherwise
        src_en = bus.async_clock_select ? (st.sync2 & ~st.xtal_prev)
                                        : 1'b1;
        next_st.sync1 = crystal_in_pin;
        next_st.sync2 = st.sync1;
        next_st.xtal_prev = st.sync2;
        if (bus.clock_select == 3'h0) begin
            next_st.pre = '0;
        end else if (src_en) begin
            next_st.pre = st.pre + PRE_W'(1);
        end
    end

    // No tick at all while the clock select field is zero
    assign bus.tick = src_en && (bus.clock_select != 3'h0) &&
        ((st.pre & mask) == mask);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    a_stop_no_tick: assert property (@(posedge clk) disable iff (!rst_n)
        bus.clock_select == 3'h0 |-> !bus.tick)
        else $error("tick while clock select is zero");
    a_async_spaced: assert property (@(posedge clk) disable iff (!rst_n)
        bus.async_clock_select && bus.tick |=> !bus.tick)
        else $error("crystal ticks on back to back cycles");
endmodule

// file: design/t8cc_wave.sv
`timescale 1ns/1ps
module t8cc_wave import t8cc_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    t8cc_if.wave bus
);
    typedef struct packed {
        logic oc;
    } t8cc_wv_s;
    t8cc_wv_s st;
    t8cc_wv_s next_st;

    // Output state update on match, force and bottom
    always_comb begin
        next_st = st;
        if (bus.match_ev || bus.force_ev) begin
            unique case (bus.waveform_mode)
                T8CC_WM_NORMAL, T8CC_WM_CLEAR, T8CC_WM_FAST: begin
                    unique case (bus.compare_output_mode)
                        2'h0: next_st.oc = st.oc;
                        2'h1: next_st.oc = ~st.oc;
                        2'h2: next_st.oc = 1'b0;
                        2'h3: next_st.oc = 1'b1;
                    endcase
                end
                T8CC_WM_PHASE: begin
                    if (bus.compare_output_mode[1]) begin
                        next_st.oc = bus.count_down ^
                            bus.compare_output_mode[0];
                    end
                end
            endcase
        end
        // Fast mode restores the level when the count wraps
        if (bus.bottom_ev && bus.compare_output_mode[1]) begin
            next_st.oc = ~bus.compare_output_mode[0];
        end
    end

    assign bus.compare_output_state = st.oc;

    // Mode changes never touch the output state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    a_com_zero_hold: assert property (@(posedge clk) disable iff (!rst_n)
        bus.compare_output_mode == 2'h0 |=> $stable(st.oc))
        else $error("output state moved with output mode zero");
    a_toggle_now: assert property (@(posedge clk) disable iff (!rst_n)
        bus.match_ev && bus.waveform_mode == T8CC_WM_CLEAR &&
        bus.compare_output_mode == 2'h1 |=> st.oc != $past(st.oc))
        else $error("toggle missed on match");
    a_mode_keep: assert property (@(posedge clk) disable iff (!rst_n)
        !bus.match_ev && !bus.force_ev && !bus.bottom_ev
        |=> $stable(st.oc))
        else $error("output state changed without an event");
endmodule

// file: dv/t8cc_pin_model.sv
`timescale 1ns/1ps
module t8cc_pin_model (
    input wire logic xtal_en,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic crystal_in_pin,
    output logic pin_level
);
    // Watch crystal, phase unrelated to clk, stands low when disabled
    initial begin
        crystal_in_pin = 1'b0;
        forever begin
            #205;
            crystal_in_pin = xtal_en ? ~crystal_in_pin : 1'b0;
        end
    end
    // Pad with a pull-up; the device drives it only while enabled
    assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule

// file: dv/timer8_compare_counter_core_test.sv
`timescale 1ns/1ps
module timer8_compare_counter_core_test;
    import t8cc_pkg::*;
    typedef struct {
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } t8cc_row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic port_value_bit = 1'b0;
    logic pin_direction_bit = 1'b0;
    logic cmp_irq_ack = 1'b0;
    logic ovf_irq_ack = 1'b0;
    logic xtal_en = 1'b0;
    logic [7:0] reg_rdata, rd_val;
    logic crystal_in_pin, compare_irq, overflow_irq;
    logic pin_out, pin_oe, pin_level;
    int error_cnt = 0;
    int samples_checked = 0;
    int n;
    t8cc_row_s rows [12];

    // System clock, 40 ns period
    always #20 clk = ~clk;

    t8cc_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .crystal_in_pin(crystal_in_pin), .port_value_bit(port_value_bit),
        .pin_direction_bit(pin_direction_bit), .cmp_irq_ack(cmp_irq_ack),
        .ovf_irq_ack(ovf_irq_ack), .compare_irq(compare_irq),
        .overflow_irq(overflow_irq), .pin_out(pin_out), .pin_oe(pin_oe));
    t8cc_pin_model u_pin (.xtal_en(xtal_en), .pin_out(pin_out),
        .pin_oe(pin_oe), .crystal_in_pin(crystal_in_pin),
        .pin_level(pin_level));

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    // One-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // Interrupt service pulse
    task automatic ack(input bit ovf);
        @(posedge clk);
        ovf_irq_ack <= ovf;
        cmp_irq_ack <= !ovf;
        @(posedge clk);
        ovf_irq_ack <= 1'b0;
        cmp_irq_ack <= 1'b0;
        #1;
    endtask
    // Cycles until a request shows, checked against a window
    task automatic wait_irq(input bit ovf, input int lo, input int hi);
        #1;
        n = 0;
        while ((ovf ? overflow_irq : compare_irq) !== 1'b1 && n <= hi) begin
            idle(1);
            n++;
        end
        chk({7'h00, n >= lo && n <= hi}, 8'h01);
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog
    initial begin
        #800000;
        error_cnt++;
        complete_run();
    end

    // Main sequence
    initial begin
        rows = '{'{OFS_INTEN, 8'h03, 8'h03}, '{OFS_ASYNC, 8'h01, 8'h01},
            '{OFS_ASYNC, 8'h00, 8'h00}, '{OFS_COUNT, 8'hFF, 8'hFF},
            '{OFS_FLAGS, 8'h00, 8'h04}, '{OFS_COUNT, 8'h00, 8'h00},
            '{OFS_FLAGS, 8'h00, 8'h08}, '{OFS_COMPARE, 8'h33, 8'h33},
            '{OFS_CTRL, 8'h60, 8'h60}, '{3'h6, 8'hFF, 8'h00},
            '{3'h7, 8'hFF, 8'h00}, '{OFS_INTEN, 8'h00, 8'h00}};
        idle(19);
        chk({5'h00, compare_irq, overflow_irq, pin_oe}, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL);
        chk(rd_val, 8'h00);
        idle(1);
        chk(reg_rdata, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk(rd_val, rows[i].e);
        end
        // Output state set up before the pin is enabled
        wr(OFS_INTEN, 8'h01);
        wr(OFS_CTRL, 8'hE0);
        idle(1);
        chk({6'h00, pin_out, compare_irq}, 8'h02);
        wr(OFS_CTRL, 8'h40);
        idle(1);
        chk({7'h00, pin_out}, 8'h01);
        wr(OFS_CTRL, 8'h78);
        idle(1);
        chk({7'h00, pin_out}, 8'h01);
        wr(OFS_CTRL, 8'h80);
        idle(1);
        chk({7'h00, pin_out}, 8'h00);
        wr(OFS_CTRL, 8'h20);
        idle(1);
        chk({7'h00, pin_out}, 8'h01);
        @(posedge clk);
        pin_direction_bit <= 1'b1;
        wr(OFS_CTRL, 8'hC0);
        idle(1);
        chk({6'h00, pin_oe, pin_level}, 8'h02);
        // Counter write equal to compare blocks the first match
        wr(OFS_CTRL, 8'h10);
        wr(OFS_COMPARE, 8'h05);
        wr(OFS_COUNT, 8'h05);
        wr(OFS_FLAGS, 8'h01);
        wr(OFS_CTRL, 8'h11);
        idle(100);
        chk({7'h00, compare_irq}, 8'h00);
        wait_irq(0, 140, 175);
        wr(OFS_CTRL, 8'h10);
        wr(OFS_FLAGS, 8'h01);
        idle(0);
        chk({7'h00, compare_irq}, 8'h00);
        wr(OFS_COMPARE, 8'h02);
        wr(OFS_COUNT, 8'h00);
        wr(OFS_CTRL, 8'h31);
        wait_irq(0, 1, 8);
        wr(OFS_CTRL, 8'h10);
        ack(0);
        chk({7'h00, compare_irq}, 8'h00);
        wr(OFS_CTRL, 8'h11);
        wait_irq(0, 0, 8);
        // Normal mode wrap and overflow, write beats the tick
        wr(OFS_FLAGS, 8'h03);
        wr(OFS_INTEN, 8'h02);
        wr(OFS_CTRL, 8'h01);
        wr(OFS_COUNT, 8'hFE);
        idle(1);
        chk({7'h00, overflow_irq}, 8'h00);
        idle(1);
        chk({7'h00, overflow_irq}, 8'h01);
        rd(OFS_COUNT);
        chk(rd_val, 8'h01);
        ack(1);
        chk({7'h00, overflow_irq}, 8'h00);
        // Fast mode: compare writes go to the buffer
        wr(OFS_CTRL, 8'h18);
        wr(OFS_COMPARE, 8'h80);
        wr(OFS_COUNT, 8'h00);
        wr(OFS_FLAGS, 8'h03);
        wr(OFS_INTEN, 8'h01);
        rd(OFS_COMPARE);
        chk(rd_val, 8'h80);
        wr(OFS_CTRL, 8'h59);
        wait_irq(0, 1, 12);
        ack(0);
        wait_irq(0, 300, 420);
        // Dual slope: overflow only back at bottom
        wr(OFS_CTRL, 8'h08);
        wr(OFS_COUNT, 8'h00);
        wr(OFS_FLAGS, 8'h03);
        wr(OFS_INTEN, 8'h02);
        wr(OFS_CTRL, 8'h49);
        wait_irq(1, 480, 540);
        // Stopped source, then crystal source
        wr(OFS_CTRL, 8'h00);
        wr(OFS_COUNT, 8'h10);
        idle(20);
        rd(OFS_COUNT);
        chk(rd_val, 8'h10);
        wr(OFS_ASYNC, 8'h01);
        wr(OFS_CTRL, 8'h01);
        idle(20);
        rd(OFS_COUNT);
        chk(rd_val, 8'h10);
        xtal_en <= 1'b1;
        idle(200);
        rd(OFS_COUNT);
        chk({7'h00, rd_val >= 8'h21 && rd_val <= 8'h26}, 8'h01);
        complete_run();
    end
endmodule
